// [verilog/lsb_pkg.sv]
// Purpose: Constants and types for the logic, shift, bit and branch slice
// Assumes: Operations arrive already decoded from the surrounding core
// Notes:   Opcode encodings live outside this slice
package lsb_pkg;
    // ==========================================
    // Widths
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int BIT_W    = 3;
    localparam int PC_W     = 15;
    localparam int OFFS_W   = 9;
    localparam int MSB_POS  = 7;
    // ==========================================
    // Reset values and PC step
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [14:0] PC_RST   = 15'h0000;
    localparam logic [14:0] PC_STEP  = 15'h0001;
    localparam logic [7:0]  ZERO_8   = 8'h00;
    // ==========================================
    // Decoded operations
    typedef enum logic [3:0] {
        LSB_OP_NONE,
        LSB_OP_AND_LITERAL_ACC,
        LSB_OP_AND_ACC_WITH_FILE,
        LSB_OP_ARITH_SHIFT_RIGHT_FILE,
        LSB_OP_BIT_CLEAR_FILE,
        LSB_OP_BIT_SET_FILE,
        LSB_OP_RELATIVE_BRANCH_LITERAL,
        LSB_OP_RELATIVE_BRANCH_ACC,
        LSB_OP_BIT_TEST_SKIP_CLEAR
    } lsb_op_t;
endpackage

// [verilog/lsb_alu.sv]
// Purpose: Combinational data path of the slice
// Assumes: Operands valid in the cycle the operation is issued
// Notes:   No state; flags reported with change strobes
`timescale 1ns/1ps
`default_nettype none
module lsb_alu
(
    input  wire logic [3:0] op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] file_data,
    input  wire logic [7:0] literal,
    input  wire logic [2:0] bit_sel,
    output logic      [7:0] result,
    output logic            result_valid,
    output logic            zero_upd,
    output logic            carry_upd,
    output logic            carry_val,
    output logic            bit_value
);
    // ==========================================
    // Operation results
    wire logic [7:0] mask_w    = 8'h01 << bit_sel;
    wire logic [7:0] and_lit_w = acc & literal;
    wire logic [7:0] and_f_w   = acc & file_data;
    wire logic [7:0] asr_w     = {file_data[lsb_pkg::MSB_POS], file_data[7:1]};
    wire logic [7:0] bcf_w     = file_data & ~mask_w;
    wire logic [7:0] bsf_w     = file_data | mask_w;
    wire lsb_pkg::lsb_op_t op_e = lsb_pkg::lsb_op_t'(op);

    assign result = (op_e == lsb_pkg::LSB_OP_AND_LITERAL_ACC)      ? and_lit_w :
                    (op_e == lsb_pkg::LSB_OP_AND_ACC_WITH_FILE)    ? and_f_w   :
                    (op_e == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE) ? asr_w   :
                    (op_e == lsb_pkg::LSB_OP_BIT_CLEAR_FILE)       ? bcf_w     :
                    (op_e == lsb_pkg::LSB_OP_BIT_SET_FILE)         ? bsf_w     :
                    lsb_pkg::ZERO_8;
    assign result_valid = (op_e == lsb_pkg::LSB_OP_AND_LITERAL_ACC)
                       || (op_e == lsb_pkg::LSB_OP_AND_ACC_WITH_FILE)
                       || (op_e == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE)
                       || (op_e == lsb_pkg::LSB_OP_BIT_CLEAR_FILE)
                       || (op_e == lsb_pkg::LSB_OP_BIT_SET_FILE);
    // Only logic and shift touch zero; bit ops leave flags alone
    assign zero_upd  = (op_e == lsb_pkg::LSB_OP_AND_LITERAL_ACC)
                    || (op_e == lsb_pkg::LSB_OP_AND_ACC_WITH_FILE)
                    || (op_e == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE);
    assign carry_upd = (op_e == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE);
    assign carry_val = file_data[0];
    assign bit_value = file_data[bit_sel];
endmodule
`default_nettype wire

// [verilog/lsb_exec.sv]
// Purpose: Executes the decoded logic, shift, bit and branch operations
// Assumes: Core issues op with issue high; file_data is the addressed register
// Notes:   Two-cycle operations hold busy for the second, no-op cycle
// Behaviour
// - Literal AND into accumulator, only zero flag changes
// - File AND with accumulator, 7-bit address, only zero flag changes
// - Destination bit zero writes accumulator, one writes file register
// - Arithmetic shift right keeps MSB, old LSB to carry, updates C and Z
// - Shift destination bit selects accumulator or source file register
// - Bit clear zeroes one indexed bit, flags untouched
// - Bit set forces one indexed bit, flags untouched
// - Literal branch loads next address plus signed 9-bit offset
// - Accumulator branch adds unsigned accumulator to next address
// - Both branch forms take two instruction cycles
// - Clear tested bit discards next instruction, two cycles total
// - Set tested bit lets next instruction run; flags never change
// - PC change or true test costs two cycles, second is no-op
`timescale 1ns/1ps
`default_nettype none
module lsb_exec
#(
    parameter int ADDR_W = 7,
    parameter int BIT_W  = 3,
    parameter int PC_W   = 15
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        issue,
    input  wire logic [3:0]  op,
    input  wire logic        dest_file,
    input  wire logic [6:0]  file_addr,
    input  wire logic [2:0]  bit_sel,
    input  wire logic [7:0]  literal,
    input  wire logic [8:0]  branch_offset,
    input  wire logic [7:0]  file_data,
    input  wire logic [14:0] next_pc,
    output logic      [7:0]  acc_ff,
    output logic             zero_ff,
    output logic             carry_ff,
    output logic             file_we_ff,
    output logic      [6:0]  file_wr_addr_ff,
    output logic      [7:0]  file_wr_data_ff,
    output logic             pc_load_ff,
    output logic      [14:0] pc_target_ff,
    output logic             discard_next_ff,
    output logic             busy_ff
);
    // ==========================================
    // Elaboration check
    // Port widths are fixed, so only the documented sizes are served
    if (lsb_pkg::DATA_W != 8 || lsb_pkg::OFFS_W != 9
        || ADDR_W != lsb_pkg::ADDR_W || BIT_W != lsb_pkg::BIT_W || PC_W != lsb_pkg::PC_W)
    begin : g_bad_width
        $error("Slice serves only 8-bit data and 9-bit offsets");
    end

    typedef enum logic {LSB_ST_RUN, LSB_ST_NOP} lsb_state_t;
    lsb_state_t state_ff;
    lsb_state_t nxt_state;

    wire logic [7:0] alu_result;
    wire logic       alu_valid;
    wire logic       alu_zero_upd;
    wire logic       alu_carry_upd;
    wire logic       alu_carry_val;
    wire logic       alu_bit;

    // ==========================================
    // Data path
    lsb_alu u_alu
    (
        .op           (op),
        .acc          (acc_ff),
        .file_data    (file_data),
        .literal      (literal),
        .bit_sel      (bit_sel),
        .result       (alu_result),
        .result_valid (alu_valid),
        .zero_upd     (alu_zero_upd),
        .carry_upd    (alu_carry_upd),
        .carry_val    (alu_carry_val),
        .bit_value    (alu_bit)
    );

    // ==========================================
    // Decode of the issued operation
    // Ops issued during the no-op cycle are ignored; core must wait on busy
    wire logic go = issue && (state_ff == LSB_ST_RUN);
    wire lsb_pkg::lsb_op_t op_e = lsb_pkg::lsb_op_t'(op);
    wire logic is_lit_and = (op_e == lsb_pkg::LSB_OP_AND_LITERAL_ACC);
    wire logic is_bitop   = (op_e == lsb_pkg::LSB_OP_BIT_CLEAR_FILE)
                         || (op_e == lsb_pkg::LSB_OP_BIT_SET_FILE);
    wire logic is_bra     = (op_e == lsb_pkg::LSB_OP_RELATIVE_BRANCH_LITERAL);
    wire logic is_brw     = (op_e == lsb_pkg::LSB_OP_RELATIVE_BRANCH_ACC);
    wire logic is_skip    = (op_e == lsb_pkg::LSB_OP_BIT_TEST_SKIP_CLEAR);
    // Literal AND always goes to W; bit ops always back to file
    wire logic to_file = alu_valid && !is_lit_and && (is_bitop || dest_file);
    wire logic to_acc  = alu_valid && !to_file;
    wire logic skip_taken = is_skip && !alu_bit;
    wire logic branch     = is_bra || is_brw;
    wire logic two_cycle  = go && (branch || skip_taken);

    // Sign extension of the 9-bit literal to PC width
    wire logic [14:0] offs_lit = {{(lsb_pkg::PC_W - lsb_pkg::OFFS_W){branch_offset[8]}},
                                  branch_offset};
    wire logic [14:0] offs_acc = {{(lsb_pkg::PC_W - lsb_pkg::DATA_W){1'b0}}, acc_ff};
    wire logic [14:0] nxt_target = next_pc + (is_bra ? offs_lit : offs_acc);
    wire logic        nxt_zero   = (alu_result == lsb_pkg::ZERO_8);

    assign nxt_state = two_cycle ? LSB_ST_NOP : LSB_ST_RUN;

    // ==========================================
    // State and architectural registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= LSB_ST_RUN;
            busy_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            busy_ff  <= two_cycle;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_ff   <= lsb_pkg::ACC_RST;
            zero_ff  <= 1'b0;
            carry_ff <= 1'b0;
        end
        else if (go)
        begin
            if (to_acc)
            begin
                acc_ff <= alu_result;
            end
            if (alu_zero_upd)
            begin
                zero_ff <= nxt_zero;
            end
            if (alu_carry_upd)
            begin
                carry_ff <= alu_carry_val;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            file_we_ff      <= 1'b0;
            file_wr_addr_ff <= 7'h00;
            file_wr_data_ff <= lsb_pkg::ZERO_8;
        end
        else
        begin
            file_we_ff <= go && to_file;
            if (go && to_file)
            begin
                file_wr_addr_ff <= file_addr;
                file_wr_data_ff <= alu_result;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc_load_ff      <= 1'b0;
            pc_target_ff    <= lsb_pkg::PC_RST;
            discard_next_ff <= 1'b0;
        end
        else
        begin
            pc_load_ff      <= go && branch;
            discard_next_ff <= go && skip_taken;
            if (go && branch)
            begin
                pc_target_ff <= nxt_target;
            end
        end
    end

    // ==========================================
    // Checks
    a_and_lit_acc: assert property (@(posedge clk) disable iff (!reset_n)
        go && is_lit_and |=> acc_ff == ($past(acc_ff) & $past(literal)) && !file_we_ff)
        else $error("literal AND result wrong");
    a_zero_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
        go && alu_zero_upd |=> zero_ff == ($past(alu_result) == 8'h00))
        else $error("zero flag wrong");
    a_dest_file_wr: assert property (@(posedge clk) disable iff (!reset_n)
        go && alu_valid && !is_lit_and && dest_file |=> file_we_ff && $stable(acc_ff))
        else $error("file destination not written");
    a_asr_carry_out: assert property (@(posedge clk) disable iff (!reset_n)
        go && op_e == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE
        |=> carry_ff == $past(file_data[0]))
        else $error("shift carry wrong");
    a_bitop_flags_kept: assert property (@(posedge clk) disable iff (!reset_n)
        go && is_bitop |=> $stable(zero_ff) && $stable(carry_ff) && file_we_ff)
        else $error("bit op touched flags");
    a_bra_target_ok: assert property (@(posedge clk) disable iff (!reset_n)
        go && is_bra |=> pc_load_ff
        && pc_target_ff == 15'($past(next_pc) + 15'(signed'($past(branch_offset)))))
        else $error("literal branch target wrong");
    a_brw_target_ok: assert property (@(posedge clk) disable iff (!reset_n)
        go && is_brw |=> pc_target_ff == 15'($past(next_pc) + 15'($past(acc_ff))))
        else $error("acc branch target wrong");
    a_two_cycle_nop: assert property (@(posedge clk) disable iff (!reset_n)
        go && (branch || skip_taken) |=> busy_ff ##1 !busy_ff)
        else $error("second cycle not single no-op");
    a_skip_set_runs: assert property (@(posedge clk) disable iff (!reset_n)
        go && is_skip && alu_bit |=> !discard_next_ff && !busy_ff && $stable(zero_ff))
        else $error("set bit skipped");

    // ==========================================
    // Checks on results written back
    a_and_file_acc: assert property (@(posedge clk) disable iff (!reset_n)
        go && op_e == lsb_pkg::LSB_OP_AND_ACC_WITH_FILE && !dest_file
        |=> acc_ff == ($past(acc_ff) & $past(file_data))
            && !file_we_ff && $stable(carry_ff))
        else $error("file AND to accumulator wrong");
    a_and_file_wr: assert property (@(posedge clk) disable iff (!reset_n)
        go && op_e == lsb_pkg::LSB_OP_AND_ACC_WITH_FILE && dest_file
        |=> file_we_ff && file_wr_addr_ff == $past(file_addr)
            && file_wr_data_ff == ($past(acc_ff) & $past(file_data)))
        else $error("file AND write back wrong");
    a_dest_acc_kept: assert property (@(posedge clk) disable iff (!reset_n)
        go && alu_valid && !is_bitop && !dest_file
        |=> !file_we_ff && acc_ff == $past(alu_result))
        else $error("accumulator destination wrote file");
    a_file_wr_held: assert property (@(posedge clk) disable iff (!reset_n)
        !(go && to_file) |=> !file_we_ff
            && $stable(file_wr_addr_ff) && $stable(file_wr_data_ff))
        else $error("file write without operation");
    a_asr_to_acc: assert property (@(posedge clk) disable iff (!reset_n)
        go && op_e == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE && !dest_file
        |=> acc_ff == {$past(file_data[7]), $past(file_data[7:1])} && !file_we_ff)
        else $error("shift into accumulator wrong");
    a_asr_to_file: assert property (@(posedge clk) disable iff (!reset_n)
        go && op_e == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE && dest_file
        |=> file_we_ff && file_wr_addr_ff == $past(file_addr) && $stable(acc_ff)
            && file_wr_data_ff == {$past(file_data[7]), $past(file_data[7:1])})
        else $error("shift back into file wrong");
    a_bit_clear_ok: assert property (@(posedge clk) disable iff (!reset_n)
        go && op_e == lsb_pkg::LSB_OP_BIT_CLEAR_FILE
        |=> file_we_ff && file_wr_addr_ff == $past(file_addr) && $stable(acc_ff)
            && file_wr_data_ff == ($past(file_data) & ~(8'h01 << $past(bit_sel))))
        else $error("bit clear wrong");
    a_bit_set_ok: assert property (@(posedge clk) disable iff (!reset_n)
        go && op_e == lsb_pkg::LSB_OP_BIT_SET_FILE
        |=> file_we_ff && file_wr_addr_ff == $past(file_addr) && $stable(zero_ff)
            && file_wr_data_ff == ($past(file_data) | (8'h01 << $past(bit_sel))))
        else $error("bit set wrong");

    // ==========================================
    // Checks on status flags
    a_carry_only_asr: assert property (@(posedge clk) disable iff (!reset_n)
        !(go && alu_carry_upd) |=> $stable(carry_ff))
        else $error("carry changed outside shift");
    a_zero_only_logic: assert property (@(posedge clk) disable iff (!reset_n)
        !(go && alu_zero_upd) |=> $stable(zero_ff))
        else $error("zero changed by op that keeps flags");
    a_skip_no_flags: assert property (@(posedge clk) disable iff (!reset_n)
        go && is_skip |=> $stable(zero_ff) && $stable(carry_ff) && $stable(acc_ff)
            && !file_we_ff && !pc_load_ff)
        else $error("bit test changed state");

    // ==========================================
    // Checks on program flow
    a_pc_target_kept: assert property (@(posedge clk) disable iff (!reset_n)
        !(go && branch) |=> !pc_load_ff && $stable(pc_target_ff))
        else $error("target moved without branch");
    a_branch_keeps_state: assert property (@(posedge clk) disable iff (!reset_n)
        go && branch |=> $stable(acc_ff) && $stable(zero_ff) && $stable(carry_ff)
            && !file_we_ff)
        else $error("branch touched data or flags");
    a_branch_two_cyc: assert property (@(posedge clk) disable iff (!reset_n)
        go && branch |=> busy_ff && pc_load_ff && !discard_next_ff)
        else $error("branch not two cycles");
    a_skip_clear_taken: assert property (@(posedge clk) disable iff (!reset_n)
        go && is_skip && !file_data[bit_sel] |=> discard_next_ff && busy_ff && !pc_load_ff)
        else $error("clear bit not skipped");
    a_nop_cycle_idle: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff == LSB_ST_NOP |=> !file_we_ff && !pc_load_ff && !discard_next_ff
            && $stable(acc_ff) && $stable(zero_ff) && $stable(carry_ff))
        else $error("no-op cycle did work");
    a_no_issue_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !(go && (alu_valid || branch || is_skip)) |=> !file_we_ff && !pc_load_ff
            && !discard_next_ff && !busy_ff && $stable(acc_ff))
        else $error("idle cycle did work");
endmodule
`default_nettype wire

// [tb/lsb_file_model.sv]
// Purpose: Data file register model facing the executor
// Assumes: Read is combinational, write lands on the rising edge
// Notes:   Bench preloads cells through mem
`timescale 1ns/1ps
`default_nettype none
module lsb_file_model
(
    input  wire logic       clk,
    input  wire logic [6:0] rd_addr,
    input  wire logic       we,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data
);
    // ==========================================
    // Storage, all 128 cells addressable
    logic [7:0] mem [128];
    initial
    begin
        for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    end
    assign rd_data = mem[rd_addr];
    always @(posedge clk)
    begin
        if (we === 1'b1) mem[wr_addr] <= wr_data;
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the slice executor
// Assumes: File model answers file_data in the same cycle
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ==========================================
    // Stimulus and observed signals
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        issue = 1'b0;
    logic [3:0]  op = 4'h0;
    logic        dest = 1'b0;
    logic [6:0]  addr = 7'h00;
    logic [2:0]  bsel = 3'h0;
    logic [7:0]  lit = 8'h00;
    logic [8:0]  offs = 9'h000;
    logic [14:0] npc = 15'h0300;
    wire logic [7:0]  fdata, acc, wdata;
    wire logic [6:0]  waddr;
    wire logic [14:0] tgt;
    wire logic        zero, carry, we, pcld, disc, busy;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    lsb_exec dut (.clk(clk), .reset_n(reset_n), .issue(issue), .op(op), .dest_file(dest),
        .file_addr(addr), .bit_sel(bsel), .literal(lit), .branch_offset(offs),
        .file_data(fdata), .next_pc(npc), .acc_ff(acc), .zero_ff(zero), .carry_ff(carry),
        .file_we_ff(we), .file_wr_addr_ff(waddr), .file_wr_data_ff(wdata), .pc_load_ff(pcld),
        .pc_target_ff(tgt), .discard_next_ff(disc), .busy_ff(busy));
    lsb_file_model fm (.clk(clk), .rd_addr(addr), .we(we), .wr_addr(waddr),
        .wr_data(wdata), .rd_data(fdata));
    // ==========================================
    // Shared tasks
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Held issue lets ops run back to back; idle ends a run
    task automatic go(input lsb_pkg::lsb_op_t o, input logic d, input logic [6:0] a,
        input logic [2:0] b, input logic [7:0] l, input logic [8:0] k);
        issue = 1'b1;
        op    = o;
        dest  = d;
        addr  = a;
        bsel  = b;
        lit   = l;
        offs  = k;
        @(negedge clk);
    endtask
    task automatic idle();
        issue = 1'b0;
        @(negedge clk);
    endtask
    task automatic results();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_and();
        fm.mem[5] = 8'hF0;
        go(lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE, 1'b0, 7'h05, 3'h0, 8'h00, 9'h000);
        check(15'(acc), 15'h00F8);
        go(lsb_pkg::LSB_OP_AND_LITERAL_ACC, 1'b0, 7'h00, 3'h0, 8'h0F, 9'h000);
        check(15'(acc), 15'h0008);
        check(15'({zero, carry}), 15'h0000);
        go(lsb_pkg::LSB_OP_AND_LITERAL_ACC, 1'b0, 7'h00, 3'h0, 8'h00, 9'h000);
        check(15'(acc), 15'h0000);
        check(15'({zero, carry}), 15'h0002);
    endtask
    task automatic t_and_acc_with_file();
        fm.mem[1] = 8'h0F;
        fm.mem[127] = 8'h3C;
        go(lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE, 1'b0, 7'h01, 3'h0, 8'h00, 9'h000);
        check(15'({acc, zero, carry}), 15'h001D);
        go(lsb_pkg::LSB_OP_AND_ACC_WITH_FILE, 1'b1, 7'h7F, 3'h0, 8'h00, 9'h000);
        check(15'({we, waddr}), 15'h00FF);
        check(15'(wdata), 15'h0004);
        check(15'({acc, zero, carry}), 15'h001D);
        go(lsb_pkg::LSB_OP_AND_ACC_WITH_FILE, 1'b0, 7'h7F, 3'h0, 8'h00, 9'h000);
        check(15'(fm.mem[127]), 15'h0004);
        check(15'({we, acc, zero, carry}), 15'h0011);
        go(lsb_pkg::LSB_OP_AND_ACC_WITH_FILE, 1'b1, 7'h05, 3'h0, 8'h00, 9'h000);
        check(15'({we, wdata, zero}), 15'h0201);
    endtask
    task automatic t_arith_shift_right_file();
        fm.mem[2] = 8'h81;
        fm.mem[3] = 8'h01;
        go(lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE, 1'b1, 7'h02, 3'h0, 8'h00, 9'h000);
        check(15'({we, wdata, zero, carry}), 15'h0701);
        go(lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT_FILE, 1'b1, 7'h03, 3'h0, 8'h00, 9'h000);
        check(15'({we, wdata, zero, carry}), 15'h0403);
        check(15'(acc), 15'h0004);
    endtask
    task automatic t_bits();
        fm.mem[10] = 8'hFF;
        fm.mem[11] = 8'h00;
        for (int b = 0; b < 8; b++)
        begin
            go(lsb_pkg::LSB_OP_BIT_CLEAR_FILE, 1'b0, 7'h0A, 3'(b), 8'h00, 9'h000);
            check(15'(wdata), 15'(8'hFF ^ (8'h01 << b)));
            go(lsb_pkg::LSB_OP_BIT_SET_FILE, 1'b0, 7'h0B, 3'(b), 8'h00, 9'h000);
            check(15'(wdata), 15'(8'h01 << b));
            check(15'({acc, zero, carry}), 15'h0013);
            idle();
            check(15'(fm.mem[10]), 15'(8'hFF ^ (8'h01 << b)));
            check(15'(fm.mem[11]), 15'(8'h01 << b));
            fm.mem[10] = 8'hFF;
            fm.mem[11] = 8'h00;
        end
        idle();
    endtask
    task automatic t_branch();
        go(lsb_pkg::LSB_OP_RELATIVE_BRANCH_LITERAL, 1'b0, 7'h00, 3'h0, 8'h00, 9'h100);
        check(15'({pcld, busy}), 15'h0003);
        check(tgt, 15'h0200);
        go(lsb_pkg::LSB_OP_AND_LITERAL_ACC, 1'b0, 7'h00, 3'h0, 8'h00, 9'h000);
        check(15'({pcld, busy, acc}), 15'h0004);
        idle();
        go(lsb_pkg::LSB_OP_RELATIVE_BRANCH_LITERAL, 1'b0, 7'h00, 3'h0, 8'h00, 9'h0FF);
        check(tgt, 15'h03FF);
        idle();
        go(lsb_pkg::LSB_OP_RELATIVE_BRANCH_ACC, 1'b0, 7'h00, 3'h0, 8'h00, 9'h000);
        check(15'({pcld, busy}), 15'h0003);
        check(tgt, 15'h0304);
        check(15'({zero, carry}), 15'h0003);
        idle();
    endtask
    task automatic t_skip();
        fm.mem[9] = 8'h04;
        go(lsb_pkg::LSB_OP_BIT_TEST_SKIP_CLEAR, 1'b0, 7'h09, 3'h2, 8'h00, 9'h000);
        check(15'({disc, busy}), 15'h0000);
        go(lsb_pkg::LSB_OP_BIT_TEST_SKIP_CLEAR, 1'b0, 7'h09, 3'h3, 8'h00, 9'h000);
        check(15'({disc, busy}), 15'h0003);
        check(15'({zero, carry}), 15'h0003);
        idle();
        check(15'({disc, busy}), 15'h0000);
        go(lsb_pkg::LSB_OP_NONE, 1'b1, 7'h09, 3'h0, 8'h00, 9'h000);
        check(15'({we, pcld, acc}), 15'h0004);
        idle();
    endtask
    // ==========================================
    // Sequence and hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            miscompares++;
            results();
        end
    end
    initial
    begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        check(15'({acc, zero, carry}), 15'h0000);
        t_and();
        t_and_acc_with_file();
        t_arith_shift_right_file();
        t_bits();
        t_branch();
        t_skip();
        results();
    end
endmodule
`default_nettype wire
